// ---- rtl/eag_defs.svh ----
// Constants for the effective address generator
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

`define EAG_ZP_HIGH      8'h00
`define EAG_ADDR_RST     16'h0000
`define EAG_BYTE_RST     8'h00
`define EAG_PTR_RST      8'h00

`endif

// ---- rtl/eag_gen.sv ----
// Effective address generator with page-zero pointer fetch
`timescale 1ns/100ps
`default_nettype none
`include "eag_defs.svh"

module eag_gen
    import eag_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Request from sequencer
    input  wire logic        REQ_VALID,
    input  wire eag_req_t    REQ,
    output logic             REQ_READY,
    // Pointer memory read port
    output logic             MEM_RD,
    output logic [15:0]      MEM_ADDR,
    input  wire logic [7:0]  MEM_DATA,
    // Result to sequencer
    output logic             RES_VALID,
    output eag_res_t         RES
);

    typedef enum logic [1:0] {
        EAG_ST_IDLE,
        EAG_ST_PLO,
        EAG_ST_PHI
    } eag_state_t;

    eag_state_t  state_ff,   nxt_state;
    eag_req_t    req_ff,     nxt_req;
    logic [7:0]  lo_ff,      nxt_lo;
    logic        rd_ff,      nxt_rd;
    logic [15:0] maddr_ff,   nxt_maddr;
    logic        rv_ff,      nxt_rv;
    eag_res_t    res_ff,     nxt_res;
    logic        ready_ff,   nxt_ready;

    logic [15:0] base;
    logic [15:0] ptr_next;
    logic [7:0]  zp_ptr;
    logic [8:0]  lo_sum;
    logic        n_f;
    logic        z_f;
    logic        c_f;
    logic        v_f;
    logic        cond_ok;
    logic        accept;

    // ------------------------------------------------------------
    // Combinational address forming
    // ------------------------------------------------------------
    always_comb
    begin
        accept    = (state_ff == EAG_ST_IDLE) && REQ_VALID && ready_ff;
        base      = {REQ.op_hi, REQ.op_lo};
        {n_f, z_f, c_f, v_f} = REQ.flags_nzcv;
        unique case (REQ.cond)
            EAG_BR_CC: cond_ok = ~c_f;
            EAG_BR_CS: cond_ok = c_f;
            EAG_BR_NE: cond_ok = ~z_f;
            EAG_BR_EQ: cond_ok = z_f;
            EAG_BR_PL: cond_ok = ~n_f;
            EAG_BR_MI: cond_ok = n_f;
            EAG_BR_VC: cond_ok = ~v_f;
            EAG_BR_VS: cond_ok = v_f;
        endcase
        zp_ptr    = (req_ff.mode == EAG_MODE_INDX) ?
                    8'(req_ff.op_lo + req_ff.idx_x) : req_ff.op_lo;
        ptr_next  = (req_ff.mode == EAG_MODE_IND) ?
                    16'({req_ff.op_hi, req_ff.op_lo} + 16'h0001) :
                    {`EAG_ZP_HIGH, 8'(zp_ptr + 8'h01)};
        lo_sum    = {1'b0, lo_ff} + {1'b0, req_ff.idx_y};

        nxt_state = state_ff;
        nxt_req   = req_ff;
        nxt_lo    = lo_ff;
        nxt_rd    = 1'b0;
        nxt_maddr = maddr_ff;
        nxt_rv    = 1'b0;
        nxt_res   = res_ff;

        unique case (state_ff)
            EAG_ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_req = REQ;
                    nxt_res = '0;
                    nxt_rv  = 1'b1;
                    unique case (REQ.mode)
                        EAG_MODE_ACC:
                            nxt_res.use_acc = 1'b1;
                        EAG_MODE_IMM:
                            nxt_res.operand_imm = 1'b1;
                        EAG_MODE_IMPL:
                            nxt_res.addr_valid = 1'b0;
                        EAG_MODE_ABS:
                        begin
                            nxt_res.addr       = base;
                            nxt_res.addr_valid = 1'b1;
                        end
                        EAG_MODE_ZP:
                        begin
                            nxt_res.addr = {`EAG_ZP_HIGH, REQ.op_lo};
                            nxt_res.addr_valid = 1'b1;
                        end
                        EAG_MODE_ZPX, EAG_MODE_ZPY:
                        begin
                            nxt_res.addr = {`EAG_ZP_HIGH, 8'(REQ.op_lo +
                                ((REQ.mode == EAG_MODE_ZPX) ?
                                 REQ.idx_x : REQ.idx_y))};
                            nxt_res.addr_valid = 1'b1;
                        end
                        EAG_MODE_ABX, EAG_MODE_ABY:
                        begin
                            nxt_res.addr = 16'(base + {8'h00,
                                ((REQ.mode == EAG_MODE_ABX) ?
                                 REQ.idx_x : REQ.idx_y)});
                            nxt_res.addr_valid = 1'b1;
                        end
                        EAG_MODE_REL:
                        begin
                            nxt_res.addr = 16'(REQ.pc_next +
                                {{8{REQ.op_lo[7]}}, REQ.op_lo});
                            nxt_res.to_pc = 1'b1;
                            nxt_res.taken = cond_ok;
                            nxt_res.addr_valid = 1'b1;
                        end
                        default:
                        begin
                            // Indirect modes fetch pointer bytes first
                            nxt_rv    = 1'b0;
                            nxt_rd    = 1'b1;
                            nxt_state = EAG_ST_PLO;
                            if (REQ.mode == EAG_MODE_IND)
                                nxt_maddr = base;
                            else if (REQ.mode == EAG_MODE_INDX)
                                nxt_maddr = {`EAG_ZP_HIGH,
                                    8'(REQ.op_lo + REQ.idx_x)};
                            else
                                nxt_maddr = {`EAG_ZP_HIGH, REQ.op_lo};
                        end
                    endcase
                end
            end
            EAG_ST_PLO:
            begin
                nxt_lo    = MEM_DATA;
                nxt_rd    = 1'b1;
                nxt_maddr = ptr_next;
                nxt_state = EAG_ST_PHI;
            end
            EAG_ST_PHI:
            begin
                nxt_res = '0;
                nxt_res.addr_valid = 1'b1;
                if (req_ff.mode == EAG_MODE_INDY)
                    nxt_res.addr = {8'(MEM_DATA + {7'h00, lo_sum[8]}),
                                    lo_sum[7:0]};
                else
                    nxt_res.addr = {MEM_DATA, lo_ff};
                nxt_res.to_pc = (req_ff.mode == EAG_MODE_IND);
                nxt_rv    = 1'b1;
                nxt_state = EAG_ST_IDLE;
            end
        endcase
        nxt_ready = (nxt_state == EAG_ST_IDLE);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_ff <= EAG_ST_IDLE;
            req_ff   <= '0;
            lo_ff    <= `EAG_BYTE_RST;
            rd_ff    <= 1'b0;
            maddr_ff <= `EAG_ADDR_RST;
            rv_ff    <= 1'b0;
            res_ff   <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            req_ff   <= nxt_req;
            lo_ff    <= nxt_lo;
            rd_ff    <= nxt_rd;
            maddr_ff <= nxt_maddr;
            rv_ff    <= nxt_rv;
            res_ff   <= nxt_res;
            ready_ff <= nxt_ready;
        end
    end

    assign REQ_READY = ready_ff;
    assign MEM_RD    = rd_ff;
    assign MEM_ADDR  = maddr_ff;
    assign RES_VALID = rv_ff;
    assign RES       = res_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_abs;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_ABS)
        |=> RES_VALID && RES.addr == $past({REQ.op_hi, REQ.op_lo});
    endproperty
    a_abs: assert property (p_abs) else $error("absolute addr");
    property p_zp;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_ZP)
        |=> RES.addr[15:8] == 8'h00;
    endproperty
    a_zp: assert property (p_zp) else $error("zero page high");
    property p_zpx;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_ZPX)
        |=> RES.addr == {8'h00, 8'($past(REQ.op_lo) + $past(REQ.idx_x))};
    endproperty
    a_zpx: assert property (p_zpx) else $error("zp indexed wrong");
    property p_aby;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_ABY)
        |=> RES.addr == 16'($past({REQ.op_hi, REQ.op_lo}) +
                           {8'h00, $past(REQ.idx_y)});
    endproperty
    a_aby: assert property (p_aby) else $error("abs indexed wrong");
    property p_impl;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_IMPL)
        |=> RES_VALID && !RES.addr_valid && !MEM_RD;
    endproperty
    a_impl: assert property (p_impl) else $error("implied addr");
    property p_rel;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_REL)
        |=> RES.addr == 16'($past(REQ.pc_next) +
            {{8{$past(REQ.op_lo[7])}}, $past(REQ.op_lo)});
    endproperty
    a_rel: assert property (p_rel) else $error("branch target wrong");
    property p_indx_ptr;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_INDX)
        |=> MEM_RD && MEM_ADDR[15:8] == 8'h00 ##1
            MEM_RD && MEM_ADDR[15:8] == 8'h00 ##1 RES_VALID;
    endproperty
    a_indx_ptr: assert property (p_indx_ptr) else $error("page zero");
    property p_wrap;
        @(posedge CLK) disable iff (!RST_N)
        (state_ff == EAG_ST_PLO && req_ff.mode != EAG_MODE_IND &&
         MEM_ADDR == 16'h00ff) |=> MEM_ADDR == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_cc;
        @(posedge CLK) disable iff (!RST_N)
        (accept && REQ.mode == EAG_MODE_REL && REQ.cond == EAG_BR_CC)
        |=> RES.taken == !$past(REQ.flags_nzcv[1]);
    endproperty
    a_cc: assert property (p_cc) else $error("carry branch wrong");

    c_indy: cover property (@(posedge CLK) disable iff (!RST_N)
        state_ff == EAG_ST_PHI && req_ff.mode == EAG_MODE_INDY && lo_sum[8]);
    c_ind: cover property (@(posedge CLK) disable iff (!RST_N)
        state_ff == EAG_ST_PHI && req_ff.mode == EAG_MODE_IND);
    c_taken: cover property (@(posedge CLK) disable iff (!RST_N)
        RES_VALID && RES.taken);

endmodule

`default_nettype wire

// ---- rtl/eag_pkg.sv ----
// Types for the effective address generator
package eag_pkg;

    // Addressing modes
    typedef enum logic [3:0] {
        EAG_MODE_ACC,
        EAG_MODE_IMM,
        EAG_MODE_ABS,
        EAG_MODE_ZP,
        EAG_MODE_ZPX,
        EAG_MODE_ZPY,
        EAG_MODE_ABX,
        EAG_MODE_ABY,
        EAG_MODE_IMPL,
        EAG_MODE_REL,
        EAG_MODE_INDX,
        EAG_MODE_INDY,
        EAG_MODE_IND
    } eag_mode_t;

    // Branch conditions
    typedef enum logic [2:0] {
        EAG_BR_CC,
        EAG_BR_CS,
        EAG_BR_NE,
        EAG_BR_EQ,
        EAG_BR_PL,
        EAG_BR_MI,
        EAG_BR_VC,
        EAG_BR_VS
    } eag_cond_t;

    // Request from sequencer
    typedef struct packed {
        eag_mode_t mode;
        eag_cond_t cond;
        logic [7:0] op_lo;
        logic [7:0] op_hi;
        logic [7:0] idx_x;
        logic [7:0] idx_y;
        logic [15:0] pc_next;
        logic [3:0] flags_nzcv;
    } eag_req_t;

    // Result to sequencer
    typedef struct packed {
        logic [15:0] addr;
        logic        addr_valid;
        logic        to_pc;
        logic        operand_imm;
        logic        use_acc;
        logic        taken;
    } eag_res_t;

endpackage

// ---- test/eag_mem_model.sv ----
// Page-zero and pointer memory seen by the generator's read port
`timescale 1ns/100ps
`default_nettype none

module eag_mem_model
(
    // Clock
    input  wire logic        CLK,
    // Read port
    input  wire logic        MEM_RD,
    input  wire logic [15:0] MEM_ADDR,
    output logic [7:0]       MEM_DATA
);
    logic [7:0] store [0:65535];
    logic [7:0] last_ff = 8'h00;

    always_ff @(posedge CLK)
    begin
        if (MEM_RD)
            last_ff <= MEM_DATA;
    end

    // Unselected port shows the inverse of the last byte, never a held value
    assign MEM_DATA = MEM_RD ? store[MEM_ADDR] : ~last_ff;
endmodule

`default_nettype wire

// ---- test/effective_address_generator_test.sv ----
// Bench for the effective address generator
`timescale 1ns/100ps
`default_nettype none

module effective_address_generator_test
    import eag_pkg::*;
;
    logic        CLK;
    logic        RST_N;
    logic        REQ_VALID;
    eag_req_t    REQ;
    logic        REQ_READY;
    logic        MEM_RD;
    logic [15:0] MEM_ADDR;
    logic [7:0]  MEM_DATA;
    logic        RES_VALID;
    eag_res_t    RES;
    eag_res_t    res_seen;
    logic [15:0] rd_q [$];
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycle_count = 0;

    eag_gen u_dut (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .REQ_VALID (REQ_VALID),
        .REQ       (REQ),
        .REQ_READY (REQ_READY),
        .MEM_RD    (MEM_RD),
        .MEM_ADDR  (MEM_ADDR),
        .MEM_DATA  (MEM_DATA),
        .RES_VALID (RES_VALID),
        .RES       (RES)
    );

    eag_mem_model u_mem (
        .CLK      (CLK),
        .MEM_RD   (MEM_RD),
        .MEM_ADDR (MEM_ADDR),
        .MEM_DATA (MEM_DATA)
    );

    // ------------------------------------------------------------
    // Clock, pointer read log and hang guard
    // ------------------------------------------------------------
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        if (MEM_RD === 1'b1)
            rd_q.push_back(MEM_ADDR);
        cycle_count++;
        if (cycle_count == 2000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic eag_req_t mk(eag_mode_t m, logic [7:0] lo,
                                    logic [7:0] hi, logic [7:0] x,
                                    logic [7:0] y);
        eag_req_t r;
        r = '0;
        r.mode = m;
        r.op_lo = lo;
        r.op_hi = hi;
        r.idx_x = x;
        r.idx_y = y;
        return r;
    endfunction

    // Entered just after a rising edge; holds the request until taken
    task automatic run(input eag_req_t r, input int lat);
        int   n;
        logic ok;
        rd_q.delete();
        REQ = r;
        REQ_VALID = 1'b1;
        ok = 1'b0;
        while (!ok)
        begin
            ok = (REQ_READY === 1'b1);
            @(posedge CLK);
            #1;
        end
        REQ_VALID = 1'b0;
        check("ready", REQ_READY, lat == 1);
        n = 1;
        while (RES_VALID !== 1'b1 && n < 8)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        res_seen = RES;
        check("latency", n, lat);
        check("reads", rd_q.size(), (lat == 3) ? 2 : 0);
        @(posedge CLK);
        #1;
        check("pulse", RES_VALID, 1'b0);
    endtask

    task automatic chk_addr(input logic [15:0] exp);
        check("addr", res_seen.addr, exp);
        check("addr_valid", res_seen.addr_valid, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_direct();
        run(mk(EAG_MODE_ABS, 8'h34, 8'h12, 8'h00, 8'h00), 1);
        chk_addr(16'h1234);
        run(mk(EAG_MODE_ZP, 8'hff, 8'hab, 8'h00, 8'h00), 1);
        chk_addr(16'h00ff);
        run(mk(EAG_MODE_ZPX, 8'hf0, 8'hab, 8'h20, 8'h00), 1);
        chk_addr(16'h0010);
        run(mk(EAG_MODE_ZPY, 8'h80, 8'hab, 8'h00, 8'hff), 1);
        chk_addr(16'h007f);
        run(mk(EAG_MODE_ABX, 8'hf0, 8'hff, 8'h20, 8'h00), 1);
        chk_addr(16'h0010);
        run(mk(EAG_MODE_ABY, 8'hff, 8'h12, 8'h00, 8'h81), 1);
        chk_addr(16'h1380);
    endtask

    task automatic t_noaddr();
        run(mk(EAG_MODE_IMPL, 8'h12, 8'h34, 8'h00, 8'h00), 1);
        check("impl_valid", res_seen.addr_valid, 1'b0);
        run(mk(EAG_MODE_IMM, 8'h12, 8'h34, 8'h00, 8'h00), 1);
        check("imm_valid", res_seen.addr_valid, 1'b0);
        check("imm_flag", res_seen.operand_imm, 1'b1);
        run(mk(EAG_MODE_ACC, 8'h12, 8'h34, 8'h00, 8'h00), 1);
        check("acc_valid", res_seen.addr_valid, 1'b0);
        check("acc_flag", res_seen.use_acc, 1'b1);
    endtask

    // Each condition with its own flag clear or set, all others opposite
    task automatic t_branch();
        eag_req_t   r;
        logic [3:0] mask;
        for (int i = 0; i < 16; i++)
        begin
            mask = (i[3:2] == 2'd3) ? 4'h1 : 4'(4'h2 << i[3:2]);
            r = mk(EAG_MODE_REL, i[0] ? 8'h80 : 8'h7f, 8'h00, 8'h00, 8'h00);
            r.cond = eag_cond_t'(i[3:1]);
            r.flags_nzcv = i[0] ? mask : ~mask;
            r.pc_next = 16'h1000;
            run(r, 1);
            check("target", res_seen.addr, i[0] ? 16'h0f80 : 16'h107f);
            check("taken", res_seen.taken, i[1] == i[0]);
        end
    endtask

    task automatic t_indirect();
        u_mem.store[16'h00ff] = 8'h34;
        u_mem.store[16'h0000] = 8'h12;
        run(mk(EAG_MODE_INDX, 8'hf0, 8'h55, 8'h0f, 8'h00), 3);
        check("x_ptr_lo", rd_q[0], 16'h00ff);
        check("x_ptr_hi", rd_q[1], 16'h0000);
        chk_addr(16'h1234);
        u_mem.store[16'h00ff] = 8'hf0;
        run(mk(EAG_MODE_INDY, 8'hff, 8'h55, 8'h00, 8'h20), 3);
        check("y_ptr_lo", rd_q[0], 16'h00ff);
        check("y_ptr_hi", rd_q[1], 16'h0000);
        chk_addr(16'h1310);
        u_mem.store[16'h12ff] = 8'hcd;
        u_mem.store[16'h1300] = 8'hab;
        run(mk(EAG_MODE_IND, 8'hff, 8'h12, 8'h00, 8'h00), 3);
        check("i_ptr_lo", rd_q[0], 16'h12ff);
        check("i_ptr_hi", rd_q[1], 16'h1300);
        chk_addr(16'habcd);
        check("to_pc", res_seen.to_pc, 1'b1);
    endtask

    // Reset in the middle of a pointer fetch, then a fresh request
    task automatic t_reset();
        REQ = mk(EAG_MODE_INDY, 8'h10, 8'h00, 8'h00, 8'h00);
        REQ_VALID = 1'b1;
        @(posedge CLK);
        #1;
        REQ_VALID = 1'b0;
        check("pre_rd", MEM_RD, 1'b1);
        RST_N = 1'b0;
        @(posedge CLK);
        #1;
        check("mid_mem_rd", MEM_RD, 1'b0);
        check("mid_ready", REQ_READY, 1'b0);
        check("mid_res_valid", RES_VALID, 1'b0);
        check("mid_res_addr", RES.addr, 16'h0000);
        RST_N = 1'b1;
        @(posedge CLK);
        #1;
        check("mid_ready_up", REQ_READY, 1'b1);
        run(mk(EAG_MODE_ZP, 8'h42, 8'h00, 8'h00, 8'h00), 1);
        chk_addr(16'h0042);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        RST_N = 1'b0;
        REQ_VALID = 1'b0;
        REQ = '0;
        repeat (3) @(posedge CLK);
        #1;
        check("rst_res_valid", RES_VALID, 1'b0);
        check("rst_mem_rd", MEM_RD, 1'b0);
        check("rst_ready", REQ_READY, 1'b0);
        RST_N = 1'b1;
        t_direct();
        t_noaddr();
        t_branch();
        t_indirect();
        t_reset();
        wrap_up();
    end
endmodule

`default_nettype wire
